// >>> rtc_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// - confirmation code is request code plus one
// - request and confirmation declare twelve byte payload
// - sub-commands: one state, two time, three load
// - state bits 1:0 carry clock type
// - state bit 2 set only if time valid
// - read time returns seconds since epoch
// - load confirmation echoes supplied seconds value
// - without backup, time restarts at preset value
// - internal clock counts a 32.768 kHz source
//////////////////////////////////////////////////////////////////////////////
package rtc_pkg;

	// packet codes
	localparam logic [31:0] TIME_REQUEST_CODE = 32'h0000_1ed8;
	localparam logic [31:0] TIME_CONFIRM_CODE = 32'h0000_1ed9;
	localparam logic [31:0] SYSTEM_QUEUE = 32'h0000_0000;
	localparam logic [31:0] PAYLOAD_BYTES = 32'h0000_000c;

	// sub-commands
	localparam logic [31:0] QUERY_CLOCK_STATE = 32'h0000_0001;
	localparam logic [31:0] QUERY_CLOCK_TIME = 32'h0000_0002;
	localparam logic [31:0] LOAD_CLOCK_TIME = 32'h0000_0003;

	// status codes, zero is success
	localparam logic [31:0] STA_OK = 32'h0000_0000;
	localparam logic [31:0] STA_BAD_SUBCMD = 32'h0000_0001;
	localparam logic [31:0] STA_BAD_CODE = 32'h0000_0002;
	localparam logic [31:0] STA_BAD_QUEUE = 32'h0000_0003;
	localparam logic [31:0] STA_BAD_LEN = 32'h0000_0004;

	// clock type encodings and state field layout
	typedef enum logic [1:0] {
		RTC_TYPE_NONE = 2'b00,
		RTC_TYPE_INTERNAL = 2'b01,
		RTC_TYPE_EXTERNAL = 2'b10,
		RTC_TYPE_EMULATED = 2'b11
	} rtc_type_t;
	localparam int unsigned TYPE_LSB = 0;
	localparam int unsigned TYPE_MSB = 1;
	localparam int unsigned VALID_BIT = 2;

	// time after power loss, arbitrary neutral value
	localparam logic [31:0] PRESET_SECONDS = 32'h0000_0000;

	// timing: system clock and the 32.768 kHz counting source
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int unsigned RTC_SRC_HZ = 32768;

	// register byte offsets
	localparam logic [7:0] OFS_REQ_CMD = 8'h00;
	localparam logic [7:0] OFS_REQ_LEN = 8'h04;
	localparam logic [7:0] OFS_REQ_DEST = 8'h08;
	localparam logic [7:0] OFS_REQ_SUB = 8'h0c;
	localparam logic [7:0] OFS_REQ_DATA = 8'h10;
	localparam logic [7:0] OFS_REQ_RES = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	localparam logic [7:0] OFS_CNF_CMD = 8'h1c;
	localparam logic [7:0] OFS_CNF_LEN = 8'h20;
	localparam logic [7:0] OFS_CNF_STA = 8'h24;
	localparam logic [7:0] OFS_CNF_SUB = 8'h28;
	localparam logic [7:0] OFS_CNF_DATA = 8'h2c;
	localparam logic [7:0] OFS_CNF_RES = 8'h30;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
	localparam logic [7:0] OFS_CONFIG = 8'h3c;

	// control, interrupt and config bits
	localparam int unsigned CTRL_GO_BIT = 0;
	localparam int unsigned IRQ_DONE_BIT = 0;
	localparam int unsigned IRQ_ERR_BIT = 1;
	localparam int unsigned IRQ_W = 2;
	localparam rtc_type_t CONFIG_RESET = RTC_TYPE_INTERNAL;

endpackage : rtc_pkg

// >>> rtc_timebase.sv
`timescale 1ns/1ps
module rtc_timebase
	import rtc_pkg::*;
#(
	parameter int unsigned SRC_PER_SEC = RTC_SRC_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	output logic sec_tick
);

	logic [31:0] acc_q;
	logic src_tick_q;
	logic [15:0] sub_q;

	//////////////////////////////////////////////////////////////////////////
	// fractional divider
	// phase accumulator makes a 32.768 kHz enable from the system clock;
	// jitter of one cycle is traded for exact long-term rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 32'h0000_0000;
			src_tick_q <= 1'b0;
		end else if (acc_q + RTC_SRC_HZ >= CLK_HZ) begin
			acc_q <= 32'(acc_q + RTC_SRC_HZ - CLK_HZ);
			src_tick_q <= 1'b1;
		end else begin
			acc_q <= 32'(acc_q + RTC_SRC_HZ);
			src_tick_q <= 1'b0;
		end
	end

	// count source ticks into whole seconds; clear restarts the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_q <= 16'h0000;
			sec_tick <= 1'b0;
		end else if (clear) begin
			sub_q <= 16'h0000;
			sec_tick <= 1'b0;
		end else if (src_tick_q) begin
			if (sub_q == 16'(SRC_PER_SEC - 1)) begin
				sub_q <= 16'h0000;
				sec_tick <= 1'b1;
			end else begin
				sub_q <= 16'(sub_q + 16'h0001);
				sec_tick <= 1'b0;
			end
		end else begin
			sec_tick <= 1'b0;
		end
	end

endmodule : rtc_timebase

// >>> rtc_cmd_top.sv
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module rtc_cmd_top
	import rtc_pkg::*;
#(
	parameter int unsigned SRC_PER_SEC = RTC_SRC_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic supply_lost,
	output logic irq
);

	logic [31:0] req_cmd_q, req_len_q, req_dest_q;
	logic [31:0] req_sub_q, req_data_q, req_res_q;
	logic [31:0] cnf_cmd_q, cnf_len_q, cnf_sta_q;
	logic [31:0] cnf_sub_q, cnf_data_q, cnf_res_q;
	logic [31:0] secs_q;
	logic valid_q;
	rtc_type_t type_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
	logic sec_tick;
	logic wr_en, go;
	logic [7:0] ofs;
	logic [31:0] sta_d;

	// register word address decode, used only for the error response
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= OFS_CONFIG);
	endfunction : mapped

	assign ofs = paddr[7:0];
	// a refused address must not land in a register behind the error
	assign wr_en = psel && penable && pready && !pslverr && pwrite;
	assign go = wr_en && (ofs == OFS_CTRL) && pwdata[CTRL_GO_BIT];

	//////////////////////////////////////////////////////////////////////////
	// apb slave: one wait-free access; ready and data set in setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= !mapped(ofs) || (paddr[31:8] != 24'h00_0000);
			prdata <= pwrite ? 32'h0000_0000 : read_word(ofs);
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

	function automatic logic [31:0] read_word(input logic [7:0] a);
		case (a)
			OFS_REQ_CMD: read_word = req_cmd_q;
			OFS_REQ_LEN: read_word = req_len_q;
			OFS_REQ_DEST: read_word = req_dest_q;
			OFS_REQ_SUB: read_word = req_sub_q;
			OFS_REQ_DATA: read_word = req_data_q;
			OFS_REQ_RES: read_word = req_res_q;
			OFS_CNF_CMD: read_word = cnf_cmd_q;
			OFS_CNF_LEN: read_word = cnf_len_q;
			OFS_CNF_STA: read_word = cnf_sta_q;
			OFS_CNF_SUB: read_word = cnf_sub_q;
			OFS_CNF_DATA: read_word = cnf_data_q;
			OFS_CNF_RES: read_word = cnf_res_q;
			OFS_IRQ_STAT: read_word = {30'h0, irq_stat_q};
			OFS_IRQ_MASK: read_word = {30'h0, irq_mask_q};
			OFS_CONFIG: read_word = {30'h0, type_q};
			default: read_word = 32'h0000_0000;
		endcase
	endfunction : read_word

	//////////////////////////////////////////////////////////////////////////
	// request packet words as the host leaves them in the mailbox
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_cmd_q <= 32'h0000_0000;
			req_len_q <= 32'h0000_0000;
			req_dest_q <= 32'h0000_0000;
			req_sub_q <= 32'h0000_0000;
			req_data_q <= 32'h0000_0000;
			req_res_q <= 32'h0000_0000;
		end else if (wr_en) begin
			case (ofs)
				OFS_REQ_CMD: req_cmd_q <= pwdata;
				OFS_REQ_LEN: req_len_q <= pwdata;
				OFS_REQ_DEST: req_dest_q <= pwdata;
				OFS_REQ_SUB: req_sub_q <= pwdata;
				OFS_REQ_DATA: req_data_q <= pwdata;
				OFS_REQ_RES: req_res_q <= pwdata;
				default: ;
			endcase
		end
	end

	// clock type configuration; software says which source is fitted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			type_q <= CONFIG_RESET;
		end else if (wr_en && ofs == OFS_CONFIG) begin
			type_q <= rtc_type_t'(pwdata[TYPE_MSB:TYPE_LSB]);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// header checks
	// the header is checked first, then the sub-command
	always_comb begin
		sta_d = STA_OK;
		if (req_cmd_q != TIME_REQUEST_CODE) begin
			sta_d = STA_BAD_CODE;
		end else if (req_dest_q != SYSTEM_QUEUE) begin
			sta_d = STA_BAD_QUEUE;
		end else if (req_len_q != PAYLOAD_BYTES) begin
			sta_d = STA_BAD_LEN;
		end else if (req_sub_q != QUERY_CLOCK_STATE &&
			req_sub_q != QUERY_CLOCK_TIME &&
			req_sub_q != LOAD_CLOCK_TIME) begin
			sta_d = STA_BAD_SUBCMD;
		end
	end

	rtc_timebase #(
		.SRC_PER_SEC(SRC_PER_SEC)
	) u_timebase (
		.pclk(pclk),
		.presetn(presetn),
		.clear(go && sta_d == STA_OK && req_sub_q == LOAD_CLOCK_TIME),
		.sec_tick(sec_tick)
	);

	//////////////////////////////////////////////////////////////////////////
	// preset after power loss
	// time counter; a load wins over a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secs_q <= PRESET_SECONDS;
			valid_q <= 1'b0;
		end else if (supply_lost) begin
			secs_q <= PRESET_SECONDS;
			valid_q <= 1'b0;
		end else if (go && sta_d == STA_OK && req_sub_q == LOAD_CLOCK_TIME) begin
			secs_q <= req_data_q;
			valid_q <= 1'b1;
		end else if (sec_tick && type_q != RTC_TYPE_NONE) begin
			secs_q <= 32'(secs_q + 32'h0000_0001);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// confirmation build
	// confirmation words are ready at the edge that takes the go write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnf_cmd_q <= 32'h0000_0000;
			cnf_len_q <= 32'h0000_0000;
			cnf_sta_q <= STA_OK;
			cnf_sub_q <= 32'h0000_0000;
			cnf_data_q <= 32'h0000_0000;
			cnf_res_q <= 32'h0000_0000;
		end else if (go) begin
			cnf_cmd_q <= TIME_CONFIRM_CODE;
			cnf_len_q <= PAYLOAD_BYTES;
			cnf_sta_q <= sta_d;
			cnf_sub_q <= req_sub_q;
			cnf_res_q <= 32'h0000_0000;
			cnf_data_q <= 32'h0000_0000;
			if (sta_d == STA_OK) begin
				case (req_sub_q)
					QUERY_CLOCK_STATE: begin
						cnf_data_q[TYPE_MSB:TYPE_LSB] <= type_q;
						cnf_data_q[VALID_BIT] <= valid_q &&
							type_q != RTC_TYPE_NONE;
					end
					QUERY_CLOCK_TIME: cnf_data_q <= secs_q;
					LOAD_CLOCK_TIME: cnf_data_q <= req_data_q;
					default: cnf_data_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q &
				~((wr_en && ofs == OFS_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0)) |
				{go && sta_d != STA_OK, go};
		end
	end

	// mask register and registered interrupt level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_en && ofs == OFS_IRQ_MASK) begin
				irq_mask_q <= pwdata[IRQ_W-1:0];
			end
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks on the command path
	sequence s_go_ok(logic [31:0] sub);
		go && sta_d == STA_OK && req_sub_q == sub;
	endsequence

	// reserved sub-command taken while no tick or power loss interferes
	sequence s_go_bad;
		go && sta_d == STA_BAD_SUBCMD && !sec_tick && !supply_lost;
	endsequence

	property p_cnf_code;
		@(posedge pclk) disable iff (!presetn)
		go |=> cnf_cmd_q == TIME_CONFIRM_CODE && cnf_sub_q == $past(req_sub_q);
	endproperty
	a_cnf_code: assert property (p_cnf_code)
		else $error("confirmation code wrong");

	property p_cnf_len;
		@(posedge pclk) disable iff (!presetn)
		go |=> cnf_len_q == PAYLOAD_BYTES && cnf_res_q == 32'h0000_0000;
	endproperty
	a_cnf_len: assert property (p_cnf_len)
		else $error("confirmation length wrong");

	property p_state_type;
		@(posedge pclk) disable iff (!presetn)
		s_go_ok(QUERY_CLOCK_STATE) |=>
			cnf_data_q[TYPE_MSB:TYPE_LSB] == $past(type_q);
	endproperty
	a_state_type: assert property (p_state_type)
		else $error("clock type field wrong");

	property p_state_valid;
		@(posedge pclk) disable iff (!presetn)
		s_go_ok(QUERY_CLOCK_STATE) |=> cnf_data_q[VALID_BIT] ==
			$past(valid_q && type_q != RTC_TYPE_NONE);
	endproperty
	a_state_valid: assert property (p_state_valid)
		else $error("time valid bit wrong");

	property p_state_upper;
		@(posedge pclk) disable iff (!presetn)
		s_go_ok(QUERY_CLOCK_STATE) |=> cnf_data_q[31:3] == 29'h0;
	endproperty
	a_state_upper: assert property (p_state_upper)
		else $error("unused state bits not zero");

	property p_get_time;
		@(posedge pclk) disable iff (!presetn)
		s_go_ok(QUERY_CLOCK_TIME) |=> cnf_data_q == $past(secs_q);
	endproperty
	a_get_time: assert property (p_get_time)
		else $error("read time data wrong");

	property p_set_echo;
		@(posedge pclk) disable iff (!presetn)
		s_go_ok(LOAD_CLOCK_TIME) ##0 !supply_lost |=>
			cnf_data_q == $past(req_data_q) && secs_q == $past(req_data_q)
			&& valid_q;
	endproperty
	a_set_echo: assert property (p_set_echo)
		else $error("load time not echoed or applied");

	property p_bad_sub;
		@(posedge pclk) disable iff (!presetn)
		s_go_bad |=>
			cnf_sta_q != STA_OK && $stable(secs_q) && $stable(valid_q)
			##1 irq_stat_q[IRQ_ERR_BIT];
	endproperty
	a_bad_sub: assert property (p_bad_sub)
		else $error("reserved sub-command mishandled");

	property p_power_loss;
		@(posedge pclk) disable iff (!presetn)
		supply_lost |=> secs_q == PRESET_SECONDS && !valid_q;
	endproperty
	a_power_loss: assert property (p_power_loss)
		else $error("time not preset after power loss");

endmodule : rtc_cmd_top

// >>> rtc_host.sv
`timescale 1ns/1ps
module rtc_host
	import rtc_pkg::*;
(
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// confirmation words in address order: cmd len sta sub data res
	logic [31:0] cnf [6];

	// bus idle at time zero
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 32'h0;
		pwdata <= 32'h0;
	end

	//////////////////////////////////////////////////////////////////////
	// one apb transfer; the leading edge keeps release and next setup
	// apart, so no signal is assigned twice in one time step
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no fixed latency assumed, the bench timeout bounds the wait
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	//////////////////////////////////////////////////////////////////////
	// full request packet, go, then fetch the confirmation
	task automatic send(input logic [31:0] sub, input logic [31:0] dat);
		logic [31:0] q;
		logic e;
		xfer(1'b1, OFS_REQ_CMD, TIME_REQUEST_CODE, q, e);
		xfer(1'b1, OFS_REQ_DEST, SYSTEM_QUEUE, q, e);
		xfer(1'b1, OFS_REQ_LEN, PAYLOAD_BYTES, q, e);
		xfer(1'b1, OFS_REQ_SUB, sub, q, e);
		xfer(1'b1, OFS_REQ_DATA, dat, q, e);
		xfer(1'b1, OFS_REQ_RES, 32'h0, q, e);
		xfer(1'b1, OFS_CTRL, 32'h1, q, e);
		for (int i = 0; i < 6; i++) begin
			xfer(1'b0, OFS_CNF_CMD + 8'(4 * i), 32'h0, cnf[i], e);
		end
	endtask : send

endmodule : rtc_host

// >>> tb_rtc_cmd_top.sv
`timescale 1ns/1ps
module tb_rtc_cmd_top;
	import rtc_pkg::*;
	// four source ticks a second keeps one second near 24k cycles
	localparam int unsigned SPS = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, q, t, sx;
	logic supply_lost, irq, e;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	logic [31:0] lfsr_q = 32'h4208;

	rtc_cmd_top #(.SRC_PER_SEC(SPS)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .supply_lost(supply_lost), .irq(irq));
	rtc_host host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	//////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// expected state word: type low, valid above, the rest zero
	function automatic logic [31:0] exp_state(input logic [1:0] ty,
		input logic v);
		return {29'h0, v, ty};
	endfunction : exp_state

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// one command and a check of every confirmation word
	task automatic run(input logic [31:0] sub, input logic [31:0] d,
		input logic [31:0] sta, input logic [31:0] exp);
		host.send(sub, d);
		chk(host.cnf[0], TIME_CONFIRM_CODE);
		chk(host.cnf[1], PAYLOAD_BYTES);
		chk(host.cnf[2], sta);
		chk(host.cnf[3], sub);
		chk(host.cnf[4], exp);
		chk(host.cnf[5], 32'h0);
	endtask : run

	// hang guard, the second-count wait dominates the run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			end_sim();
		end
	end

	//////////////////////////////////////////////////////////////////////
	initial begin
		presetn <= 1'b0;
		supply_lost <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		host.xfer(1'b0, OFS_CONFIG, 32'h0, q, e);
		chk(q, {30'h0, CONFIG_RESET});
		run(QUERY_CLOCK_STATE, 32'h0, STA_OK, exp_state(2'h1, 1'b0));
		run(QUERY_CLOCK_TIME, 32'h0, STA_OK, PRESET_SECONDS);
		// loads: top boundary, then a random value
		for (int i = 0; i < 2; i++) begin
			lfsr_q = lfsr(lfsr_q);
			t = (i == 0) ? 32'hffff_ffff : lfsr_q;
			run(LOAD_CLOCK_TIME, t, STA_OK, t);
			run(QUERY_CLOCK_TIME, 32'h0, STA_OK, t);
		end
		run(QUERY_CLOCK_STATE, 32'h0, STA_OK, exp_state(2'h1, 1'b1));
		// reserved sub-commands must leave the clock alone
		for (int i = 0; i < 3; i++) begin
			lfsr_q = lfsr(lfsr_q);
			q = (i == 0) ? 32'h0 : (i == 1) ? 32'h4 : (lfsr_q | 32'h80);
			run(q, 32'h0, STA_BAD_SUBCMD, 32'h0);
		end
		run(QUERY_CLOCK_TIME, 32'h0, STA_OK, t);
		// one second of a small source count has passed by then
		repeat (30000) @(posedge pclk);
		run(QUERY_CLOCK_TIME, 32'h0, STA_OK, t + 32'h1);
		// every clock type; none ends in time not valid
		for (int ty = 3; ty >= 0; ty--) begin
			host.xfer(1'b1, OFS_CONFIG, {30'h0, 2'(ty)}, q, e);
			run(QUERY_CLOCK_STATE, 32'h0, STA_OK,
				exp_state(2'(ty), ty != 0));
		end
		host.xfer(1'b1, OFS_CONFIG, 32'h1, q, e);
		// power loss without backup
		supply_lost <= 1'b1;
		repeat (2) @(posedge pclk);
		supply_lost <= 1'b0;
		run(QUERY_CLOCK_STATE, 32'h0, STA_OK, exp_state(2'h1, 1'b0));
		run(QUERY_CLOCK_TIME, 32'h0, STA_OK, PRESET_SECONDS);
		// broken header words one at a time, each put back afterwards
		for (int i = 0; i < 3; i++) begin
			t = (i == 0) ? TIME_REQUEST_CODE :
				(i == 1) ? PAYLOAD_BYTES : SYSTEM_QUEUE;
			sx = (i == 0) ? STA_BAD_CODE :
				(i == 1) ? STA_BAD_LEN : STA_BAD_QUEUE;
			host.xfer(1'b1, OFS_REQ_CMD + 8'(4 * i), 32'h5, q, e);
			host.xfer(1'b1, OFS_CTRL, 32'h1, q, e);
			host.xfer(1'b0, OFS_CNF_STA, 32'h0, q, e);
			chk(q, sx);
			host.xfer(1'b0, OFS_CNF_DATA, 32'h0, q, e);
			chk(q, 32'h0);
			host.xfer(1'b1, OFS_REQ_CMD + 8'(4 * i), t, q, e);
		end
		// interrupt: masked, sticky, then enabled and cleared
		chk({31'h0, irq}, 32'h0);
		host.xfer(1'b0, OFS_IRQ_STAT, 32'h0, q, e);
		chk(q, 32'h3);
		host.xfer(1'b1, OFS_IRQ_STAT, 32'h3, q, e);
		host.xfer(1'b0, OFS_IRQ_STAT, 32'h0, q, e);
		chk(q, 32'h0);
		host.xfer(1'b1, OFS_IRQ_MASK, 32'h1, q, e);
		run(QUERY_CLOCK_STATE, 32'h0, STA_OK, exp_state(2'h1, 1'b0));
		chk({31'h0, irq}, 32'h1);
		host.xfer(1'b1, OFS_IRQ_STAT, 32'h1, q, e);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		// unmapped address is refused with an error and zero data
		host.xfer(1'b0, 8'h40, 32'h0, q, e);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		end_sim();
	end

endmodule : tb_rtc_cmd_top
